// ### rtl/iplr_pkg.sv
// package: register map, field layout and shared types of the interrupt priority level registers
// Overview of operation
// RL1 - debug sources: code 00 off, 01..11 give levels 1..3; level 0 unreachable
// RL2 - other sources: code 00 off, 01..11 give levels 0..2; level 3 unreachable
// RL3 - debug register: rx full bits 5-4, tx empty bits 3-2, trace bits 1-0
// RL4 - reserved bits read zero and ignore writes in all four priority registers
// RL5 - system register: flash buffers empty 15-14, command done 13-12, error 11-10
// RL6 - system register: pll unlock in bits 9-8, low voltage in bits 7-6
// RL7 - system register: external pin b in bits 3-2, pin a in bits 1-0
// RL8 - port/can register: port d 15-14, port e 13-12, port f 11-10
// RL9 - port/can register: can msgbuf 9-8, wakeup 7-6, error 5-4, busoff 3-2
// RL10 - serial register: serial0 rx 15-14, serial1 tx 13-12, serial1 rx 11-10
// RL11 - serial register: port a bits 5-4, port b 3-2, port c 1-0
// RL12 - reset clears every field to 00 so all sources start disabled
// RL13 - each register sits at the block base plus its own word offset
// RL14 - vector address joins the vector base with the winning source's vector number
// RL15 - disabled sources never arbitrate; a written field acts from the next cycle
package iplr_pkg;

    localparam int unsigned N_SRC   = 23;
    localparam int unsigned N_DBG   = 3;
    localparam int unsigned N_IPR   = 4;
    localparam int unsigned ADDR_W  = 8;
    localparam int unsigned IDX_W   = 6;
    localparam int unsigned VNUM_W  = 5;
    localparam int unsigned VBASE_W = 11;
    localparam int unsigned N_EVT   = 2;

    // register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_DEBUG  = 6'h01;
    localparam logic [IDX_W-1:0] IDX_SYSTEM = 6'h02;
    localparam logic [IDX_W-1:0] IDX_PORT   = 6'h03;
    localparam logic [IDX_W-1:0] IDX_SERIAL = 6'h04;
    localparam logic [IDX_W-1:0] IDX_VBASE  = 6'h10;
    localparam logic [IDX_W-1:0] IDX_STATUS = 6'h11;
    localparam logic [IDX_W-1:0] IDX_CLEAR  = 6'h12;
    localparam logic [IDX_W-1:0] IDX_ENABLE = 6'h13;

    localparam logic [15:0] IPR_RESET = 16'h0000;
    // writable bits per priority register, debug/system/port/serial
    localparam logic [15:0] IPR_WMASK [N_IPR] = '{16'h003F, 16'hFFCF, 16'hFFFC, 16'hFC3F};

    // source index is the vector number; debug sources first
    // 0 trace, 1 debug tx, 2 debug rx, 3 pin a, 4 pin b, 5 low voltage, 6 pll,
    // 7 flash err, 8 flash done, 9 flash empty, 10 busoff, 11 can err, 12 wakeup,
    // 13 msgbuf, 14 port f, 15 port e, 16 port d, 17 port c, 18 port b, 19 port a,
    // 20 serial1 rx, 21 serial1 tx, 22 serial0 rx
    localparam int unsigned SRC_REG [N_SRC] = '{0, 0, 0, 1, 1, 1, 1, 1, 1, 1, 2, 2,
                                               2, 2, 2, 2, 2, 3, 3, 3, 3, 3, 3};
    localparam int unsigned SRC_LSB [N_SRC] = '{0, 2, 4, 0, 2, 6, 8, 10, 12, 14, 2, 4,
                                               6, 8, 10, 12, 14, 0, 2, 4, 10, 12, 14};

    localparam logic [1:0] CODE_OFF = 2'h0;
    localparam logic [1:0] CODE_ONE = 2'h1;

    localparam int unsigned EVT_GRANT  = 0;
    localparam int unsigned EVT_BUSERR = 1;

    typedef struct packed {
        logic             valid;
        logic [IDX_W-1:0] idx;
        logic [15:0]      data;
    } iplr_wr_s;

    typedef struct packed {
        logic              valid;
        logic [1:0]        level;
        logic [VNUM_W-1:0] vnum;
    } iplr_grant_s;

endpackage : iplr_pkg

// ### rtl/iplr_apb_slave.sv
// module: apb slave front end with one wait-free access phase
`timescale 1ns/1ps
`default_nettype none
module iplr_apb_slave
    import iplr_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic              rd_hit,
    input  wire logic [15:0]       rd_word,
    output logic      [IDX_W-1:0]  acc_idx,
    output iplr_wr_s               wr,
    output logic                   bus_err_evt,
    output logic                   pready,
    output logic      [31:0]       prdata,
    output logic                   pslverr
);

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } iplr_apb_s;

    iplr_apb_s st_reg;
    iplr_apb_s st_next;
    logic      hit;
    logic      setup;
    logic      access;

    assign acc_idx = paddr[ADDR_W-1:2]; // RL13
    // misaligned byte addresses never map onto a register
    assign hit     = rd_hit && (paddr[1:0] == 2'h0);
    assign setup   = psel && !penable;
    assign access  = psel && penable && st_reg.pready;

    assign wr.valid    = access && pwrite && hit;
    assign wr.idx      = acc_idx;
    assign wr.data     = pwdata[15:0];
    assign bus_err_evt = access && !hit;

    always_comb begin
        st_next         = st_reg;
        // answer is prepared in setup so every bus output is a flop
        st_next.pready  = setup;
        st_next.pslverr = setup && !hit;
        st_next.prdata  = (setup && !pwrite && hit) ? {16'h0000, rd_word} : 32'h0000_0000;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign pready  = st_reg.pready;
    assign pslverr = st_reg.pslverr;
    assign prdata  = st_reg.prdata;

endmodule : iplr_apb_slave
`default_nettype wire

// ### rtl/iplr_arbiter.sv
// module: level decode per source and highest level selection
`timescale 1ns/1ps
`default_nettype none
module iplr_arbiter
    import iplr_pkg::*;
(
    input  wire logic [N_IPR-1:0][15:0] ipr_words,
    input  wire logic [N_SRC-1:0]       src_req,
    output iplr_grant_s                 grant
);

    logic [N_SRC-1:0] active;
    logic [1:0]       lvl [N_SRC];

    for (genvar i = 0; i < N_SRC; i++) begin : g_src
        logic [1:0] code;
        assign code      = ipr_words[SRC_REG[i]][SRC_LSB[i] +: 2];
        assign active[i] = src_req[i] && (code != CODE_OFF); // RL15
        if (i < N_DBG) begin : g_dbg
            assign lvl[i] = code; // RL1
        end else begin : g_per
            assign lvl[i] = 2'(code - CODE_ONE); // RL2
        end
    end

    // scan from the top so the lowest vector number wins a tie
    always_comb begin
        grant = '0;
        for (int i = N_SRC - 1; i >= 0; i--) begin
            if (active[i] && (!grant.valid || lvl[i] >= grant.level)) begin
                grant.valid = 1'b1;
                grant.level = lvl[i];
                grant.vnum  = VNUM_W'(i);
            end
        end
    end

endmodule : iplr_arbiter
`default_nettype wire

// ### rtl/iplr_top.sv
// module: priority level register file, arbitration output and event interrupt
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module iplr_top
    import iplr_pkg::*;
(
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [ADDR_W-1:0]         paddr,
    input  wire logic [31:0]               pwdata,
    output logic                           pready,
    output logic      [31:0]               prdata,
    output logic                           pslverr,
    input  wire logic [N_SRC-1:0]          src_req,
    output logic                           irq_valid,
    output logic      [1:0]                irq_level,
    output logic      [VBASE_W+VNUM_W-1:0] irq_vector,
    output logic                           irq_out
);

    typedef struct packed {
        logic [N_IPR-1:0][15:0] ipr;
        logic [VBASE_W-1:0]     vbase;
        logic [N_EVT-1:0]       evt_en;
        logic [N_EVT-1:0]       evt_sts;
        logic                   gnt_valid;
        logic [1:0]             gnt_level;
        logic [VNUM_W-1:0]      gnt_vnum;
        logic [VBASE_W-1:0]     gnt_vbase;
        logic                   irq;
    } iplr_top_s;

    iplr_top_s   st_reg;
    iplr_top_s   st_next;
    logic [IDX_W-1:0] acc_idx;
    iplr_wr_s    wr;
    logic        bus_err_evt;
    logic        rd_hit;
    logic [15:0] rd_word;
    iplr_grant_s grant;
    logic [N_EVT-1:0] evt;
    logic [N_EVT-1:0] clr;

    iplr_apb_slave u_apb (
        .pclk        (pclk),
        .presetn     (presetn),
        .psel        (psel),
        .penable     (penable),
        .pwrite      (pwrite),
        .paddr       (paddr),
        .pwdata      (pwdata),
        .rd_hit      (rd_hit),
        .rd_word     (rd_word),
        .acc_idx     (acc_idx),
        .wr          (wr),
        .bus_err_evt (bus_err_evt),
        .pready      (pready),
        .prdata      (prdata),
        .pslverr     (pslverr)
    );

    // arbitrates on the stored fields, so a write acts one cycle later
    iplr_arbiter u_arb (
        .ipr_words (st_reg.ipr),
        .src_req   (src_req),
        .grant     (grant)
    );

    // read decode; stored fields already hold zero in reserved bits
    always_comb begin
        rd_hit  = 1'b1;
        rd_word = 16'h0000;
        case (acc_idx)
            IDX_DEBUG: begin
                rd_word = st_reg.ipr[0]; // RL3 RL4
            end
            IDX_SYSTEM: begin
                rd_word = st_reg.ipr[1]; // RL5 RL6 RL7
            end
            IDX_PORT: begin
                rd_word = st_reg.ipr[2]; // RL8 RL9
            end
            IDX_SERIAL: begin
                rd_word = st_reg.ipr[3]; // RL10 RL11
            end
            IDX_VBASE: begin
                rd_word = 16'(st_reg.vbase);
            end
            IDX_STATUS: begin
                rd_word = 16'(st_reg.evt_sts);
            end
            IDX_CLEAR: begin
                rd_word = 16'h0000;
            end
            IDX_ENABLE: begin
                rd_word = 16'(st_reg.evt_en);
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    always_comb begin
        st_next = st_reg;
        evt     = '0;
        clr     = '0;

        for (int k = 0; k < N_IPR; k++) begin
            if (wr.valid && (wr.idx == IDX_DEBUG + IDX_W'(k))) begin
                st_next.ipr[k] = wr.data & IPR_WMASK[k]; // RL4 RL13
            end
        end
        if (wr.valid && (wr.idx == IDX_VBASE)) begin
            st_next.vbase = wr.data[VBASE_W-1:0];
        end
        if (wr.valid && (wr.idx == IDX_ENABLE)) begin
            st_next.evt_en = wr.data[N_EVT-1:0];
        end
        if (wr.valid && (wr.idx == IDX_CLEAR)) begin
            clr = wr.data[N_EVT-1:0];
        end

        // a new winner, or the winner moving to another source or level
        evt[EVT_GRANT]  = grant.valid && (!st_reg.gnt_valid || (grant.vnum != st_reg.gnt_vnum)
                          || (grant.level != st_reg.gnt_level));
        evt[EVT_BUSERR] = bus_err_evt;
        // an event in the clearing cycle survives the clear
        st_next.evt_sts = (st_reg.evt_sts & ~clr) | evt;
        st_next.irq     = |(st_next.evt_sts & st_next.evt_en);

        st_next.gnt_valid = grant.valid; // RL15
        st_next.gnt_level = grant.level;
        st_next.gnt_vnum  = grant.vnum;
        st_next.gnt_vbase = st_reg.vbase; // RL14
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0; // RL12
        end else begin
            st_reg <= st_next;
        end
    end

    assign irq_valid  = st_reg.gnt_valid;
    assign irq_level  = st_reg.gnt_level;
    assign irq_vector = {st_reg.gnt_vbase, st_reg.gnt_vnum}; // RL14
    assign irq_out    = st_reg.irq;

endmodule : iplr_top
`default_nettype wire

// ### test/iplr_top_properties.sv
// checker: port-level properties of the priority level register block
`timescale 1ns/1ps
`default_nettype none
module iplr_top_properties
    import iplr_pkg::*;
(
    input wire logic                      pclk,
    input wire logic                      presetn,
    input wire logic                      psel,
    input wire logic                      penable,
    input wire logic                      pwrite,
    input wire logic [ADDR_W-1:0]         paddr,
    input wire logic                      pready,
    input wire logic [31:0]               prdata,
    input wire logic                      pslverr,
    input wire logic [N_SRC-1:0]          src_req,
    input wire logic                      irq_valid,
    input wire logic [1:0]                irq_level,
    input wire logic [VBASE_W+VNUM_W-1:0] irq_vector
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    // address is still held by the master while pready is sampled
    sequence s_rd(a);
        pready && !pwrite && paddr == a;
    endsequence
    a_ready_after_setup: assert property (s_setup |=> pready)
        else $error("pready missing after setup");
    a_ready_has_cause: assert property (pready |-> $past(psel && !penable))
        else $error("pready without setup");
    a_upper_half_zero: assert property (pready |-> prdata[31:16] == 16'h0000)
        else $error("upper read bits set");
    a_dbg_rsvd_zero: assert property (s_rd(8'h04) |-> prdata[15:6] == 10'h000)
        else $error("debug reserved bits set");
    a_sys_rsvd_zero: assert property (s_rd(8'h08) |-> prdata[5:4] == 2'h0)
        else $error("system reserved bits set");
    a_port_rsvd_zero: assert property (s_rd(8'h0C) |-> prdata[1:0] == 2'h0)
        else $error("port reserved bits set");
    a_ser_rsvd_zero: assert property (s_rd(8'h10) |-> prdata[9:6] == 4'h0)
        else $error("serial reserved bits set");
    a_err_reads_zero: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
        else $error("error response carries data");
    a_idle_no_irq: assert property ($past(src_req) == {N_SRC{1'b0}} |-> !irq_valid)
        else $error("request presented with no source active");
    a_dbg_never_zero: assert property (irq_valid && irq_vector[4:0] < 5'h03 |-> irq_level != 2'h0)
        else $error("debug source at level 0");
    a_other_never_3: assert property (irq_valid && irq_vector[4:0] >= 5'h03 |-> irq_level != 2'h3)
        else $error("peripheral source at level 3");
endmodule : iplr_top_properties
bind iplr_top iplr_top_properties u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pready,
    .prdata, .pslverr, .src_req, .irq_valid, .irq_level, .irq_vector);
`default_nettype wire

// ### test/iplr_core_model.sv
// partner model: processor core taking the presented request
`timescale 1ns/1ps
`default_nettype none
module iplr_core_model
    import iplr_pkg::*;
(
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      irq_valid,
    input  wire logic [VBASE_W+VNUM_W-1:0] irq_vector,
    output logic      [VBASE_W+VNUM_W-1:0] taken_vec
);
    // keeps the last fetched vector, so a dropped request does not erase it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            taken_vec <= {(VBASE_W+VNUM_W){1'b0}};
        end else if (irq_valid) begin
            taken_vec <= irq_vector;
        end
    end
endmodule : iplr_core_model
`default_nettype wire

// ### test/tb_irq_priority_level_regs.sv
// testbench: register file, arbitration and event interrupt against a reference model
`timescale 1ns/1ps
`default_nettype none
module tb_irq_priority_level_regs;
    import iplr_pkg::*;
    logic             pclk = 1'b0;
    logic             presetn = 1'b0;
    logic             psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]       paddr = 8'h00;
    logic [31:0]      pwdata = 32'h0000_0000, rd, prdata;
    logic             pready, pslverr, irq_valid, irq_out, er;
    logic [1:0]       irq_level;
    logic [15:0]      irq_vector, taken_vec;
    logic [N_SRC-1:0] src_req = {N_SRC{1'b0}}, req;
    logic [15:0]      ipr [N_IPR];
    int               fails = 0, tests_run = 0, seed = 45, vb, bl, bs, code, lvl;
    always #25 pclk = ~pclk;
    iplr_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
        .src_req, .irq_valid, .irq_level, .irq_vector, .irq_out);
    iplr_core_model core (.pclk, .presetn, .irq_valid, .irq_vector, .taken_vec);
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        // read right after the edge, pready still holds the value sampled at it
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            fails++;
            wrap_up();
        end
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic reset_check;
        for (int i = 0; i < N_IPR; i++) begin
            apb(1'b0, 8'((i + 1) * 4), 32'h0000_0000);
            chk(rd, 32'h0000_0000);
        end
        $display("reset value test done");
    endtask : reset_check
    task automatic irq_is(input logic e);
        @(negedge pclk);
        chk(irq_out, e);
    endtask : irq_is
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        reset_check();
        repeat (12) begin
            for (int i = 0; i < N_IPR; i++) begin
                vb = $random(seed);
                ipr[i] = 16'(vb) & IPR_WMASK[i];
                apb(1'b1, 8'((i + 1) * 4), 32'(vb));
                apb(1'b0, 8'((i + 1) * 4), 32'h0000_0000);
                chk(rd, {16'h0000, ipr[i]});
            end
            vb = $random(seed) & 32'h0000_07FF;
            apb(1'b1, 8'h40, 32'(vb));
            req = N_SRC'($random(seed) & $random(seed));
            src_req <= req;
            bl = -1;
            for (int s = 0; s < N_SRC; s++) begin
                code = int'((ipr[SRC_REG[s]] >> SRC_LSB[s]) & 16'h0003);
                lvl = (s < N_DBG) ? code : code - 1;
                if (req[s] && code != 0 && lvl > bl) begin
                    bl = lvl;
                    bs = s;
                end
            end
            repeat (2) @(posedge pclk);
            @(negedge pclk);
            chk(irq_valid, 32'(bl >= 0));
            if (bl >= 0) begin
                chk({irq_level, irq_vector}, {14'h0000, bl[1:0], vb[10:0], bs[4:0]});
                chk(taken_vec, {vb[10:0], bs[4:0]});
            end
        end
        $display("register and arbitration test done");
        apb(1'b0, 8'h20, 32'h0000_0000);
        chk({er, rd[30:0]}, 32'h8000_0000);
        apb(1'b1, 8'h48, 32'h0000_0003);
        apb(1'b1, 8'h4C, 32'h0000_0002);
        irq_is(1'b0);
        apb(1'b0, 8'h05, 32'h0000_0000);
        chk({er, rd[30:0]}, 32'h8000_0000);
        irq_is(1'b1);
        apb(1'b1, 8'h4C, 32'h0000_0000);
        irq_is(1'b0);
        apb(1'b1, 8'h4C, 32'h0000_0002);
        irq_is(1'b1);
        apb(1'b0, 8'h44, 32'h0000_0000);
        chk(rd, 32'h0000_0002);
        apb(1'b1, 8'h48, 32'h0000_0002);
        irq_is(1'b0);
        $display("interrupt test done");
        // reset again with fields, enables and requests all loaded
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        chk({irq_valid, irq_out, pready}, 32'h0000_0000);
        presetn <= 1'b1;
        src_req <= N_SRC'(1);
        reset_check();
        apb(1'b1, 8'h4C, 32'h0000_0001);
        apb(1'b1, 8'h04, 32'h0000_0001);
        irq_is(1'b0);
        chk(irq_valid, 32'h0000_0000);
        irq_is(1'b1);
        chk({irq_level, irq_vector}, 32'h0001_0000);
        apb(1'b1, 8'h48, 32'h0000_0001);
        irq_is(1'b0);
        $display("grant event test done");
        wrap_up();
    end
endmodule : tb_irq_priority_level_regs
`default_nettype wire
